// ### rtl/cbseq_top.sv
`timescale 1ns/1ps
module cbseq_top
	import cbseq_pkg::*;
(
	input  wire logic                  i_clk,
	input  wire logic                  i_srst,
	input  wire logic                  i_req_valid,
	input  wire cbseq_pkg::cbseq_req_t i_req,
	input  wire logic                  i_irq,
	input  wire logic                  i_wake,
	input  wire logic [15:0]           i_rdata,
	input  wire logic                  i_ack,
	input  wire logic [15:0]           i_extended_control_reg,
	output logic                       o_req_ready,
	output cbseq_pkg::cbseq_cyc_t      o_cyc,
	output logic                       o_internal,
	output logic [15:0]                o_wdata,
	output logic [AW-1:0]              o_move_source_addr,
	output logic [AW-1:0]              o_move_dest_addr,
	output logic [AW-1:0]              o_start_addr,
	output logic                       o_done
);
	import cbseq_pkg::*;

	typedef enum logic [4:0] {
		S_IDLE, S_VEC, S_VEC2, S_INT_B, S_HFET, S_FET, S_NEXT, S_PREF, S_INT_A,
		S_PUSH_L, S_PUSH_H, S_PUSH_X, S_TAS_W, S_MV_RD, S_MV_WR, S_MR_INT, S_MR_H, S_MR_L
	} cbseq_state_t;

	cbseq_state_t  state;
	cbseq_op_t     op;
	logic [AW-1:0] addr;
	logic [AW-1:0] ret_pc;
	logic [AW-1:0] sp;
	logic [AW-1:0] ea;
	logic [AW-1:0] vec;
	logic [1:0]    extra;
	logic          wake;
	logic          is_bus;
	logic          step;
	logic          cnt_load;
	logic [15:0]   cnt_value;
	logic          cnt_dec;
	logic [15:0]   cnt;
	logic          cnt_last;
	logic [15:0]   move_count;

	// ==========================================================
	// Bus cycle presentation
	always_comb begin
		is_bus = !(state inside {S_IDLE, S_INT_A, S_INT_B, S_MR_INT}) && !(state == S_PREF && wake);
		o_cyc.valid     = is_bus;
		o_cyc.write     = state inside {S_PUSH_L, S_PUSH_H, S_PUSH_X, S_TAS_W, S_MV_WR}
		                  || (state inside {S_MR_H, S_MR_L} && op == OP_MULTI_REG_PUSH);
		o_cyc.byte_size = state inside {S_TAS_W, S_MV_RD, S_MV_WR};
		o_cyc.locked    = (state == S_VEC);
		o_cyc.addr      = addr;
		o_internal      = !is_bus && (state != S_IDLE);
		step            = is_bus ? i_ack : (state != S_IDLE);
		o_req_ready     = (state == S_IDLE) && !i_irq;
	end

	// Move count from the low byte or the low word
	assign move_count = i_req.count_is_word ? i_req.count_reg : {8'h00, i_req.count_reg[7:0]};

	// Counter load and decrement
	assign cnt_load  = (state == S_IDLE) && o_req_ready && i_req_valid;
	assign cnt_value = (i_req.op == OP_BLOCK_MOVE) ? move_count : {13'h0000, i_req.reg_count};
	assign cnt_dec   = i_ack && (state == S_MV_WR || state == S_MR_L);

	cbseq_counter #(.W(16)) cbseq_counter_inst (
		.i_clk   (i_clk),
		.i_srst  (i_srst),
		.i_load  (cnt_load),
		.i_value (cnt_value),
		.i_dec   (cnt_dec),
		.o_count (cnt),
		.o_last  (cnt_last)
	);

	// ==========================================================
	// Sequencer state and address
	always_ff @(posedge i_clk) begin
		o_done <= 1'b0;
		if (i_srst) begin
			state <= S_VEC;
			addr  <= RESET_VEC;
			vec   <= RESET_VEC;
			op    <= OP_ALU_REG;
			extra <= 2'h0;
			wake  <= 1'b0;
			ret_pc <= '0;
			sp    <= '0;
			ea    <= '0;
		end else begin
			case (state)
				S_IDLE: begin
					if (i_irq) begin
						state  <= S_PREF;
						addr   <= i_req.pc + WORD_STEP;
						ret_pc <= i_req.pc;
						sp     <= i_req.sp;
						vec    <= i_req.vector_address;
						wake   <= i_wake;
					end else if (i_req_valid) begin
						op    <= i_req.op;
						addr  <= i_req.pc;
						ea    <= i_req.ea;
						sp    <= i_req.sp;
						vec   <= i_req.vector_address;
						ret_pc <= i_req.pc;
						wake  <= 1'b0;
						extra <= 2'h0;
						case (i_req.op)
							OP_ALU_IMM16, OP_TEST_AND_SET, OP_MULTI_REG_PUSH, OP_MULTI_REG_POP: begin
								state <= S_FET;
								extra <= IMM16_FETCH;
							end
							OP_ALU_IMM32: begin
								state <= S_FET;
								extra <= IMM32_FETCH;
							end
							OP_BLOCK_MOVE: begin
								state <= (move_count == 16'h0000) ? S_IDLE : S_MV_RD;
								addr  <= i_req.gp_reg_five;
								o_done <= (move_count == 16'h0000);
							end
							default: begin
								state <= S_NEXT;
							end
						endcase
					end
				end
				S_FET: begin
					if (step) begin
						addr  <= addr + WORD_STEP;
						extra <= extra - 2'h1;
						state <= (extra == 2'h1) ? S_NEXT : S_FET;
					end
				end
				S_NEXT: begin
					if (step) begin
						case (op)
							OP_TEST_AND_SET: begin
								state <= S_TAS_W;
								addr  <= ea;
							end
							OP_SOFTWARE_TRAP: begin
								state  <= S_INT_A;
								ret_pc <= addr + WORD_STEP;
							end
							OP_MULTI_REG_PUSH, OP_MULTI_REG_POP: begin
								state <= S_MR_INT;
								addr  <= (op == OP_MULTI_REG_PUSH) ? sp - WORD_STEP : sp;
							end
							default: begin
								state  <= S_IDLE;
								o_done <= 1'b1;
							end
						endcase
					end
				end
				S_PREF: begin
					if (step) begin
						state <= S_INT_A;
					end
				end
				S_INT_A: begin
					state <= S_PUSH_L;
					addr  <= sp - WORD_STEP;
				end
				S_PUSH_L: begin
					if (step) begin
						state <= S_PUSH_H;
						addr  <= addr - WORD_STEP;
					end
				end
				S_PUSH_H: begin
					if (step) begin
						state <= S_PUSH_X;
						addr  <= addr - WORD_STEP;
					end
				end
				S_PUSH_X: begin
					if (step) begin
						state <= S_VEC;
						addr  <= vec;
					end
				end
				S_VEC: begin
					if (step) begin
						state <= S_VEC2;
						addr  <= vec + WORD_STEP;
					end
				end
				S_VEC2: begin
					if (step) begin
						state <= S_INT_B;
					end
				end
				S_INT_B: begin
					state <= S_HFET;
					addr  <= o_start_addr;
				end
				S_HFET, S_TAS_W: begin
					if (step) begin
						state  <= S_IDLE;
						o_done <= 1'b1;
					end
				end
				S_MV_RD: begin
					if (step) begin
						state <= S_MV_WR;
						addr  <= o_move_dest_addr;
					end
				end
				S_MV_WR: begin
					if (step) begin
						state  <= cnt_last ? S_IDLE : S_MV_RD;
						addr   <= o_move_source_addr + MOVE_STEP;
						o_done <= cnt_last;
					end
				end
				S_MR_INT: begin
					state <= S_MR_H;
				end
				S_MR_H: begin
					if (step) begin
						state <= S_MR_L;
						addr  <= (op == OP_MULTI_REG_PUSH) ? addr - WORD_STEP : addr + WORD_STEP;
					end
				end
				S_MR_L: begin
					if (step) begin
						state  <= cnt_last ? S_IDLE : S_MR_H;
						addr   <= (op == OP_MULTI_REG_PUSH) ? addr - WORD_STEP : addr + WORD_STEP;
						o_done <= cnt_last;
					end
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Block-move address registers
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_move_source_addr <= '0;
			o_move_dest_addr   <= '0;
		end else if (cnt_load && i_req.op == OP_BLOCK_MOVE) begin
			o_move_source_addr <= i_req.gp_reg_five;
			o_move_dest_addr   <= i_req.gp_reg_six;
		end else if (state == S_MV_WR && i_ack) begin
			o_move_source_addr <= o_move_source_addr + MOVE_STEP;
			o_move_dest_addr   <= o_move_dest_addr + MOVE_STEP;
		end
	end

	// Start address loaded from the vector words
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_start_addr <= '0;
		end else if (state == S_VEC && i_ack) begin
			o_start_addr <= {i_rdata, o_start_addr[15:0]};
		end else if (state == S_VEC2 && i_ack) begin
			o_start_addr <= {o_start_addr[AW-1:16], i_rdata};
		end
	end

	// Stack write data
	always_comb begin
		case (state)
			S_PUSH_L: o_wdata = ret_pc[15:0];
			S_PUSH_H: o_wdata = ret_pc[AW-1:16];
			S_PUSH_X: o_wdata = i_extended_control_reg;
			default:  o_wdata = 16'h0000;
		endcase
	end

	// ==========================================================
	// Checks
	property p_reset_vec;
		@(posedge i_clk) $fell(i_srst) |-> (o_cyc.locked && o_cyc.addr == RESET_VEC && !o_cyc.write);
	endproperty
	a_reset_vec: assert property (p_reset_vec) else $error("reset vector read missing");

	property p_vec2;
		@(posedge i_clk) disable iff (i_srst)
		(state == S_VEC && i_ack) |=> (o_cyc.addr == vec + WORD_STEP && !o_cyc.locked);
	endproperty
	a_vec2: assert property (p_vec2) else $error("second vector read wrong");

	property p_int_after_vec;
		@(posedge i_clk) disable iff (i_srst)
		(state == S_VEC2 && i_ack) |=> o_internal ##1 (o_cyc.valid && o_cyc.addr == o_start_addr);
	endproperty
	a_int_after_vec: assert property (p_int_after_vec) else $error("no internal then fetch");

	property p_push_order;
		@(posedge i_clk) disable iff (i_srst)
		(state == S_PUSH_L && i_ack) |=> (o_wdata == ret_pc[AW-1:16] && o_cyc.write);
	endproperty
	a_push_order: assert property (p_push_order) else $error("high push not after low");

	property p_irq_entry;
		@(posedge i_clk) disable iff (i_srst)
		(state == S_IDLE && i_irq) |=> (state == S_PREF && addr == $past(i_req.pc) + WORD_STEP);
	endproperty
	a_irq_entry: assert property (p_irq_entry) else $error("prefetch address wrong");

	property p_wake;
		@(posedge i_clk) disable iff (i_srst)
		(state == S_PREF && wake) |-> (!o_cyc.valid && o_internal);
	endproperty
	a_wake: assert property (p_wake) else $error("bus read during wake prefetch");

	property p_move_inc;
		@(posedge i_clk) disable iff (i_srst)
		(state == S_MV_WR && i_ack) |=> o_move_dest_addr == $past(o_move_dest_addr) + MOVE_STEP;
	endproperty
	a_move_inc: assert property (p_move_inc) else $error("destination not incremented");

	property p_move_src;
		@(posedge i_clk) disable iff (i_srst)
		(state == S_MV_WR && i_ack && !cnt_last)
		|=> (o_cyc.addr == $past(o_move_source_addr) + MOVE_STEP);
	endproperty
	a_move_src: assert property (p_move_src) else $error("source not advanced");

	property p_move_cnt;
		@(posedge i_clk) disable iff (i_srst)
		(state == S_MV_RD) |-> (cnt != 16'h0000);
	endproperty
	a_move_cnt: assert property (p_move_cnt) else $error("transfer with zero count");

	property p_move_zero;
		@(posedge i_clk) disable iff (i_srst)
		(cnt_load && i_req.op == OP_BLOCK_MOVE && move_count == 16'h0000) |=> (state == S_IDLE && o_done);
	endproperty
	a_move_zero: assert property (p_move_zero) else $error("zero count moved data");

	property p_multi_pair;
		@(posedge i_clk) disable iff (i_srst)
		(state == S_MR_H && i_ack) |=> state == S_MR_L;
	endproperty
	a_multi_pair: assert property (p_multi_pair) else $error("stack pair broken");

	property p_tas_byte;
		@(posedge i_clk) disable iff (i_srst)
		(state == S_NEXT && op == OP_TEST_AND_SET && i_ack)
		|=> (o_cyc.write && o_cyc.byte_size && o_cyc.addr == ea);
	endproperty
	a_tas_byte: assert property (p_tas_byte) else $error("test-and-set write wrong");

	property p_imm32;
		@(posedge i_clk) disable iff (i_srst)
		(cnt_load && i_req.op == OP_ALU_IMM32) |=> (state == S_FET && extra == IMM32_FETCH);
	endproperty
	a_imm32: assert property (p_imm32) else $error("32-bit immediate fetch count wrong");
endmodule : cbseq_top

// ### include/cbseq_pkg.sv
package cbseq_pkg;

	// ==========================================================
	// Widths, reset vector and stepping figures
	localparam int          AW          = 32;
	localparam logic [31:0] RESET_VEC   = 32'h0000_0000;
	localparam logic [31:0] WORD_STEP   = 32'h0000_0002;
	localparam logic [31:0] MOVE_STEP   = 32'h0000_0001;
	localparam logic [1:0]  IMM16_FETCH = 2'h1;
	localparam logic [1:0]  IMM32_FETCH = 2'h2;
	localparam logic [2:0]  REG_MIN     = 3'h2;
	localparam logic [2:0]  REG_MAX     = 3'h4;

	// ==========================================================
	// Instruction classes offered by the decoder
	typedef enum logic [3:0] {
		OP_ALU_REG,
		OP_ALU_IMM16,
		OP_ALU_IMM32,
		OP_TEST_AND_SET,
		OP_SOFTWARE_TRAP,
		OP_BLOCK_MOVE,
		OP_MULTI_REG_PUSH,
		OP_MULTI_REG_POP
	} cbseq_op_t;

	// ==========================================================
	// One bus cycle towards the bus controller
	typedef struct packed {
		logic          valid;
		logic          write;
		logic          byte_size;
		logic          locked;
		logic [AW-1:0] addr;
	} cbseq_cyc_t;

	// Operands presented with a request
	typedef struct packed {
		cbseq_op_t     op;
		logic [AW-1:0] pc;
		logic [AW-1:0] sp;
		logic [AW-1:0] ea;
		logic [AW-1:0] vector_address;
		logic [AW-1:0] gp_reg_five;
		logic [AW-1:0] gp_reg_six;
		logic [15:0]   count_reg;
		logic          count_is_word;
		logic [2:0]    reg_count;
	} cbseq_req_t;

endpackage : cbseq_pkg

// ### rtl/cbseq_counter.sv
`timescale 1ns/1ps
// Loadable down counter for repeat and transfer counts
module cbseq_counter #(
	parameter int W = 16
) (
	input  wire logic         i_clk,
	input  wire logic         i_srst,
	input  wire logic         i_load,
	input  wire logic [W-1:0] i_value,
	input  wire logic         i_dec,
	output logic      [W-1:0] o_count,
	output logic              o_last
);
	// ==========================================================
	// Count register
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_count <= '0;
		end else if (i_load) begin
			o_count <= i_value;
		end else if (i_dec && (o_count != '0)) begin
			o_count <= o_count - W'(1);
		end
	end

	// One pass left
	assign o_last = (o_count == W'(1));
endmodule : cbseq_counter

// ### verification/cbseq_mem_model.sv
`timescale 1ns/1ps
// ==========================
// Bus controller stand-in, answers after i_delay cycles
module cbseq_mem_model
	import cbseq_pkg::*;
(
	input  wire logic                  i_clk,
	input  wire logic                  i_srst,
	input  wire cbseq_pkg::cbseq_cyc_t i_cyc,
	input  wire logic [1:0]            i_delay,
	output logic                       o_ack,
	output logic [15:0]                o_rdata
);
	logic [1:0] wait_cnt;

	// Data toggles outside ack so stale values never match
	initial begin
		o_ack = 1'b0;
		o_rdata = 16'h0000;
		wait_cnt = 2'h0;
	end
	always @(negedge i_clk) begin
		o_rdata = ~o_rdata;
		if (o_ack || i_srst || !i_cyc.valid) begin
			o_ack = 1'b0;
			wait_cnt = 2'h0;
		end else if (wait_cnt >= i_delay) begin
			o_ack = 1'b1;
			o_rdata = i_cyc.addr[15:0] + 16'h0100; // Read data derived from address
		end else
			wait_cnt = wait_cnt + 2'h1;
	end
endmodule : cbseq_mem_model

// ### verification/cbseq_top_test.sv
`timescale 1ns/1ps
module cbseq_top_test;
	import cbseq_pkg::*;
	typedef logic [51:0] cbseq_ev_t;
	localparam cbseq_ev_t INT_EV = {1'b1, 51'h0};
	logic          i_clk, i_srst, i_req_valid, i_irq, i_wake, i_ack;
	cbseq_req_t    i_req;
	logic [15:0]   i_rdata, i_extended_control_reg, o_wdata;
	logic          o_req_ready, o_internal, o_done;
	cbseq_cyc_t    o_cyc;
	logic [AW-1:0] o_move_source_addr, o_move_dest_addr, o_start_addr;
	logic [1:0]    delay;
	cbseq_ev_t     ev_mask;
	cbseq_ev_t     log_q[$];
	cbseq_ev_t     exp_q[$];
	int            n_fail, cmp_count;

	cbseq_top cbseq_top_inst (.i_clk(i_clk), .i_srst(i_srst), .i_req_valid(i_req_valid),
		.i_req(i_req), .i_irq(i_irq), .i_wake(i_wake), .i_rdata(i_rdata), .i_ack(i_ack),
		.i_extended_control_reg(i_extended_control_reg), .o_req_ready(o_req_ready),
		.o_cyc(o_cyc), .o_internal(o_internal), .o_wdata(o_wdata),
		.o_move_source_addr(o_move_source_addr), .o_move_dest_addr(o_move_dest_addr),
		.o_start_addr(o_start_addr), .o_done(o_done));
	cbseq_mem_model cbseq_mem_model_inst (.i_clk(i_clk), .i_srst(i_srst), .i_cyc(o_cyc),
		.i_delay(delay), .o_ack(i_ack), .o_rdata(i_rdata));

	// Clock 40 MHz
	initial i_clk = 1'b0;
	always #12.5 i_clk = ~i_clk;

	// Log every completed bus cycle and internal state
	always @(posedge i_clk) begin
		if (!i_srst && o_cyc.valid && i_ack)
			log_q.push_back({1'b0, o_cyc.write, o_cyc.byte_size, o_cyc.locked, o_cyc.addr, o_wdata});
		if (!i_srst && o_internal)
			log_q.push_back(INT_EV);
	end

	function automatic cbseq_ev_t rd(input logic [31:0] a, input logic b, input logic lk);
		return {1'b0, 1'b0, b, lk, a, 16'h0000};
	endfunction : rd
	function automatic cbseq_ev_t wr(input logic [31:0] a, input logic b, input logic [15:0] d);
		return {1'b0, 1'b1, b, 1'b0, a, d};
	endfunction : wr
	// Handler address as assembled from the model's vector data
	function automatic logic [31:0] hnd(input logic [31:0] v);
		return {v[15:0] + 16'h0100, v[15:0] + 16'h0102};
	endfunction : hnd

	task automatic chk(input logic [51:0] seen, input logic [51:0] want);
		cmp_count++;
		if (seen !== want) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : chk

	task automatic results();
		$display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results

	// Request handed over at the edge where ready is high
	task automatic send(input cbseq_req_t r);
		log_q.delete();
		i_req = r;
		i_req_valid = 1'b1;
		@(posedge i_clk);
		while (o_req_ready !== 1'b1)
			@(posedge i_clk);
		@(negedge i_clk);
		i_req_valid = 1'b0;
	endtask : send

	// Wait for completion, then compare the cycle log
	task automatic wait_done();
		int t;
		t = 0;
		do begin
			@(posedge i_clk);
			t++;
		end while (o_done !== 1'b1 && t < 600);
		chk(52'(o_done), 52'h1);
		@(negedge i_clk);
		chk(52'(log_q.size()), 52'(exp_q.size()));
		for (int k = 0; k < exp_q.size() && k < log_q.size(); k++)
			chk(log_q[k] & ev_mask, exp_q[k] & ev_mask);
		exp_q.delete();
	endtask : wait_done

	task automatic t_reset();
		log_q.delete();
		i_srst = 1'b1;
		repeat (8) @(negedge i_clk);
		i_srst = 1'b0;
		ev_mask = '1;
		exp_q = '{rd(RESET_VEC, 0, 1), rd(RESET_VEC + WORD_STEP, 0, 0), INT_EV,
			rd(hnd(RESET_VEC), 0, 0)};
		wait_done();
		chk(52'(o_start_addr), 52'(hnd(RESET_VEC)));
		$display("test reset done");
	endtask : t_reset

	task automatic t_alu_tas();
		cbseq_req_t r;
		r = '0;
		r.pc = 32'h0000_1000;
		ev_mask = {52{1'b1}} << 16;
		for (int n = 0; n < 3; n++) begin
			r.op = cbseq_op_t'(4'(n));
			for (int k = 0; k <= n; k++)
				exp_q.push_back(rd(r.pc + 32'(2 * k), 0, 0));
			send(r);
			wait_done();
		end
		r.op = OP_TEST_AND_SET;
		r.ea = 32'h0000_3001; // Address register limited to registers 0, 1, 4, 5
		exp_q = '{rd(r.pc, 0, 0), rd(r.pc + 32'h2, 0, 0), wr(r.ea, 1, 16'h0000)};
		send(r);
		wait_done();
		$display("test alu and test_and_set done");
	endtask : t_alu_tas

	// Trap and interrupt entry, wake replaces the prefetch
	task automatic t_exc(input int kind);
		cbseq_req_t r;
		logic [31:0] pv;
		r = '0;
		r.pc = 32'h0001_4000;
		r.sp = 32'h0000_8000;
		r.vector_address = 32'h0000_0040;
		pv = (kind == 0) ? r.pc + 32'h2 : r.pc;
		ev_mask = '1;
		if (kind == 0)
			exp_q = '{rd(r.pc, 0, 0)};
		else
			exp_q = '{(kind == 2) ? INT_EV : rd(pv + 32'h2, 0, 0)};
		exp_q = {exp_q, INT_EV, wr(r.sp - 32'h2, 0, pv[15:0]), wr(r.sp - 32'h4, 0, pv[31:16]),
			wr(r.sp - 32'h6, 0, i_extended_control_reg), rd(r.vector_address, 0, 1),
			rd(r.vector_address + 32'h2, 0, 0), INT_EV, rd(hnd(r.vector_address), 0, 0)};
		if (kind == 0) begin
			r.op = OP_SOFTWARE_TRAP;
			send(r);
		end else begin
			log_q.delete();
			i_req = r;
			i_irq = 1'b1;
			i_wake = (kind == 2);
			#1;
			chk(52'(o_req_ready), 52'h0);
			@(negedge i_clk);
			i_irq = 1'b0;
		end
		wait_done();
		$display("test exception entry %0d done", kind);
	endtask : t_exc

	task automatic t_move(input logic [15:0] cnt, input logic wd, input int n);
		cbseq_req_t r;
		r = '0;
		r.op = OP_BLOCK_MOVE;
		r.gp_reg_five = 32'h0000_A0FF;
		r.gp_reg_six = 32'h0000_B000;
		r.count_reg = cnt;
		r.count_is_word = wd;
		ev_mask = {4'hE, {32{1'b1}}, 16'h0000};
		for (int k = 0; k < n; k++)
			exp_q = {exp_q, rd(r.gp_reg_five + 32'(k), 1, 0), wr(r.gp_reg_six + 32'(k), 1, 0)};
		send(r);
		wait_done();
		chk(52'(o_move_source_addr), 52'(r.gp_reg_five + 32'(n)));
		chk(52'(o_move_dest_addr), 52'(r.gp_reg_six + 32'(n)));
		$display("test move of %0d done", n);
	endtask : t_move

	task automatic t_multi();
		cbseq_req_t r;
		r = '0;
		r.sp = 32'h0000_7000;
		ev_mask = {4'hE, {32{1'b1}}, 16'h0000};
		for (int c = 2; c <= 4; c++) begin
			r.reg_count = 3'(c); // Within REG_MIN to REG_MAX
			r.op = OP_MULTI_REG_PUSH;
			exp_q = '{rd(r.pc, 0, 0), rd(r.pc + 32'h2, 0, 0), INT_EV};
			for (int k = 0; k < 2 * c; k++)
				exp_q.push_back(wr(r.sp - 32'(2 * (k + 1)), 0, 16'h0000));
			send(r);
			wait_done();
			r.op = OP_MULTI_REG_POP;
			exp_q = '{rd(r.pc, 0, 0), rd(r.pc + 32'h2, 0, 0), INT_EV};
			for (int k = 0; k < 2 * c; k++)
				exp_q.push_back(rd(r.sp + 32'(2 * k), 0, 0));
			send(r);
			wait_done();
		end
		$display("test multi push and pop done");
	endtask : t_multi

	// Main sequence
	initial begin
		i_srst = 1'b1;
		i_req_valid = 1'b0;
		i_req = '0;
		i_irq = 1'b0;
		i_wake = 1'b0;
		i_extended_control_reg = 16'h0701;
		delay = 2'h0;
		ev_mask = '1;
		n_fail = 0;
		cmp_count = 0;
		@(negedge i_clk);
		t_reset();
		delay = 2'h2;
		t_alu_tas();
		for (int k = 0; k < 3; k++)
			t_exc(k);
		delay = 2'h0;
		t_move(16'hFF03, 1'b0, 3);
		t_move(16'h0002, 1'b1, 2);
		t_move(16'h0100, 1'b0, 0);
		t_multi();
		send('{op: OP_BLOCK_MOVE, count_reg: 16'h00FF, default: '0});
		repeat (6) @(negedge i_clk);
		t_reset();
		results();
	end

	// Watchdog against a hung sequence
	initial begin
		repeat (20000) @(posedge i_clk);
		n_fail++;
		results();
	end
endmodule : cbseq_top_test
